// file: rtl/tcc_top.sv
// Channel 2/3 mode control block with its AXI4-Lite register slave
//
// Notes on behaviour
// - Input mode reads filter and prescaler fields from the same bits.
// - Direction select writes take effect only while the channel is disabled.
// - Channel 3 direction: output, own input, channel 2 input, internal trigger.
// - Channel 2 direction: output, own input, channel 3 input, internal trigger.
// - Compare clear enable forces prepare low while external trigger is high.
// - Prepare is active high; polarity of outputs is applied downstream.
// - Timing mode holds the prepare signal unchanged.
// - On match: code 001 sets, 010 clears, 011 toggles prepare.
// - Code 100 forces prepare low, code 101 forces it high.
// - PWM mode 0: high below compare counting up, low above counting down.
// - PWM mode 1: inverse of PWM mode 0.
// - PWM level changes only on entry from timing, comparison change or counting direction change.
// - Compare control writes ignored under full lock in output mode.
// - Shadowed compare value moves to active value only at update events.
// - Fast enable in PWM treats a trigger edge as a compare match.
// - Filter accepts a new level after a run of equal samples.
// - Filter codes 0 to 15: off, 2/4/8 at timer clock, then dead-time rates.
// - Prescaler captures on every 1, 2, 4 or 8 edges.
// - Prescaler counter clears while the channel enable is low.
//
// Our own choice: the AXI4-Lite interface to the registers.
`include "tcc_map.svh"

module tcc_top #(
  parameter int AW = 8,
  parameter int CW = 16,
  parameter int DTS_DIV = 1
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [AW-1:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [AW-1:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  input wire logic [CW-1:0] counter_value,
  input wire logic count_down,
  input wire logic update_event,
  input wire logic trigger_edge,
  input wire logic internal_trigger,
  input wire logic filtered_external_trigger,
  input wire logic ch2_channel_enable,
  input wire logic ch3_channel_enable,
  input wire logic [1:0] output_lock_level,
  input wire logic ch2_raw_input,
  input wire logic ch3_raw_input,
  output logic ch2_prepare_signal,
  output logic ch3_prepare_signal,
  output logic ch2_capture_event,
  output logic ch3_capture_event
);

  logic [15:0] cfg_r;
  logic [CW-1:0] cmp2_r, cmp3_r;
  logic [AW-1:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0] wstrb_r;
  logic aw_full_r, w_full_r;
  logic wr_fire, wr_ok, wr_hit;
  logic [31:0] rd_val;
  logic rd_hit;
  logic [7:0] dts_cnt_r;
  logic dts_en_r;
  logic [7:0] ch2_b, ch3_b;
  logic ch2_filt, ch3_filt;

  // One channel byte after a write: direction and locked fields may be kept
  function automatic logic [7:0] cfg_byte(input logic [7:0] old, input logic [7:0] wd,
                                          input logic en, input logic [1:0] lock);
    logic [7:0] b;
    b = wd;
    if (en) begin
      b[`TCC_F_MS] = old[`TCC_F_MS];
    end
    if (lock == `TCC_LOCK_FULL && old[`TCC_F_MS] == 2'b00) begin
      b[`TCC_F_CTL] = old[`TCC_F_CTL];
      b[`TCC_F_SEN] = old[`TCC_F_SEN];
    end
    return b;
  endfunction

  assign ch2_b = cfg_r[`TCC_CH2_LSB +: 8];
  assign ch3_b = cfg_r[`TCC_CH3_LSB +: 8];

  // Write address channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready <= 1'b1;
      aw_full_r <= 1'b0;
      awaddr_r <= '0;
    end else if (awvalid && awready) begin
      awready <= 1'b0;
      aw_full_r <= 1'b1;
      awaddr_r <= awaddr;
    end else if (wr_fire) begin
      awready <= 1'b1;
      aw_full_r <= 1'b0;
    end
  end

  // Write data channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      wready <= 1'b1;
      w_full_r <= 1'b0;
      wdata_r <= 32'h0000_0000;
      wstrb_r <= 4'h0;
    end else if (wvalid && wready) begin
      wready <= 1'b0;
      w_full_r <= 1'b1;
      wdata_r <= wdata;
      wstrb_r <= wstrb;
    end else if (wr_fire) begin
      wready <= 1'b1;
      w_full_r <= 1'b0;
    end
  end

  // Write decode; narrow writes are refused
  assign wr_fire = aw_full_r && w_full_r && !bvalid;
  assign wr_hit = awaddr_r == AW'(`TCC_CFG_OFF) || awaddr_r == AW'(`TCC_CMP2_OFF) ||
                  awaddr_r == AW'(`TCC_CMP3_OFF) || awaddr_r == AW'(`TCC_STAT_OFF);
  assign wr_ok = wr_fire && wr_hit && wstrb_r == `TCC_STRB_FULL;

  // Write response
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid <= 1'b0;
      bresp <= `TCC_RESP_OKAY;
    end else if (wr_fire) begin
      bvalid <= 1'b1;
      if (!wr_hit) begin
        bresp <= `TCC_RESP_DECERR;
      end else if (wstrb_r != `TCC_STRB_FULL) begin
        bresp <= `TCC_RESP_SLVERR;
      end else begin
        bresp <= `TCC_RESP_OKAY;
      end
    end else if (bvalid && bready) begin
      bvalid <= 1'b0;
    end
  end

  // Configuration register; upper half is not stored
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cfg_r <= `TCC_CFG_RST;
    end else if (wr_ok && awaddr_r == AW'(`TCC_CFG_OFF)) begin
      cfg_r[`TCC_CH2_LSB +: 8] <= cfg_byte(ch2_b, wdata_r[`TCC_CH2_LSB +: 8],
                                           ch2_channel_enable, output_lock_level);
      cfg_r[`TCC_CH3_LSB +: 8] <= cfg_byte(ch3_b, wdata_r[`TCC_CH3_LSB +: 8],
                                           ch3_channel_enable, output_lock_level);
    end
  end

  // Written compare values
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp2_r <= CW'(`TCC_CMP_RST);
      cmp3_r <= CW'(`TCC_CMP_RST);
    end else if (wr_ok && awaddr_r == AW'(`TCC_CMP2_OFF)) begin
      cmp2_r <= wdata_r[CW-1:0];
    end else if (wr_ok && awaddr_r == AW'(`TCC_CMP3_OFF)) begin
      cmp3_r <= wdata_r[CW-1:0];
    end
  end

  // Read decode
  always_comb begin
    rd_hit = 1'b1;
    rd_val = 32'h0000_0000;
    if (araddr == AW'(`TCC_CFG_OFF)) begin
      rd_val = {16'h0000, cfg_r};
    end else if (araddr == AW'(`TCC_CMP2_OFF)) begin
      rd_val[CW-1:0] = cmp2_r;
    end else if (araddr == AW'(`TCC_CMP3_OFF)) begin
      rd_val[CW-1:0] = cmp3_r;
    end else if (araddr == AW'(`TCC_STAT_OFF)) begin
      rd_val = {`TCC_STAT_PAD, ch3_filt, ch2_filt, ch3_prepare_signal, ch2_prepare_signal};
    end else begin
      rd_hit = 1'b0;
    end
  end

  // Read channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready <= 1'b1;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= `TCC_RESP_OKAY;
    end else if (arvalid && arready) begin
      arready <= 1'b0;
      rvalid <= 1'b1;
      rdata <= rd_val;
      rresp <= rd_hit ? `TCC_RESP_OKAY : `TCC_RESP_DECERR;
    end else if (rvalid && rready) begin
      rvalid <= 1'b0;
      arready <= 1'b1;
    end
  end

  // Dead-time clock enable from the timer clock
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dts_cnt_r <= 8'h00;
      dts_en_r <= 1'b0;
    end else if (dts_cnt_r >= 8'(DTS_DIV - 1)) begin
      dts_cnt_r <= 8'h00;
      dts_en_r <= 1'b1;
    end else begin
      dts_cnt_r <= dts_cnt_r + 8'h01;
      dts_en_r <= 1'b0;
    end
  end

  // Channel 2 compare output
  tcc_out_chan #(.CW(CW)) u_out2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .out_mode(ch2_b[`TCC_F_MS] == 2'b00),
    .mode(ch2_b[`TCC_F_CTL]),
    .clear_en(ch2_b[`TCC_F_CEN]),
    .shadow_en(ch2_b[`TCC_F_SEN]),
    .fast_en(ch2_b[`TCC_F_FEN]),
    .cmp_wr(cmp2_r),
    .cnt(counter_value),
    .count_down(count_down),
    .update_ev(update_event),
    .trig_edge(trigger_edge),
    .ext_trig(filtered_external_trigger),
    .prep(ch2_prepare_signal)
  );

  // Channel 3 compare output
  tcc_out_chan #(.CW(CW)) u_out3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .out_mode(ch3_b[`TCC_F_MS] == 2'b00),
    .mode(ch3_b[`TCC_F_CTL]),
    .clear_en(ch3_b[`TCC_F_CEN]),
    .shadow_en(ch3_b[`TCC_F_SEN]),
    .fast_en(ch3_b[`TCC_F_FEN]),
    .cmp_wr(cmp3_r),
    .cnt(counter_value),
    .count_down(count_down),
    .update_ev(update_event),
    .trig_edge(trigger_edge),
    .ext_trig(filtered_external_trigger),
    .prep(ch3_prepare_signal)
  );

  // Channel 2 input path; its other source is channel 3
  tcc_in_chan u_in2 (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_in(ch2_raw_input),
    .other_filt(ch3_filt),
    .itrig(internal_trigger),
    .dts_en(dts_en_r),
    .chan_en(ch2_channel_enable),
    .ms(ch2_b[`TCC_F_MS]),
    .flt(ch2_b[`TCC_F_FLT]),
    .psc(ch2_b[`TCC_F_PSC]),
    .filt(ch2_filt),
    .capture(ch2_capture_event)
  );

  // Channel 3 input path; its other source is channel 2
  tcc_in_chan u_in3 (
    .aclk(aclk),
    .aresetn(aresetn),
    .raw_in(ch3_raw_input),
    .other_filt(ch2_filt),
    .itrig(internal_trigger),
    .dts_en(dts_en_r),
    .chan_en(ch3_channel_enable),
    .ms(ch3_b[`TCC_F_MS]),
    .flt(ch3_b[`TCC_F_FLT]),
    .psc(ch3_b[`TCC_F_PSC]),
    .filt(ch3_filt),
    .capture(ch3_capture_event)
  );

  // Checks on bus handshakes
  sequence s_wr_pair;
    aw_full_r && w_full_r && !bvalid;
  endsequence

  sequence s_narrow_wr;
    wr_fire && wstrb_r != `TCC_STRB_FULL;
  endsequence

  a_write_answered: assert property (@(posedge aclk) disable iff (!aresetn)
    s_wr_pair |=> bvalid)
    else $error("write not answered next cycle");

  a_bresp_held: assert property (@(posedge aclk) disable iff (!aresetn)
    bvalid && !bready |=> bvalid && $stable(bresp))
    else $error("write response dropped early");

  a_narrow_refused: assert property (@(posedge aclk) disable iff (!aresetn)
    s_narrow_wr |=> $stable(cfg_r) && bvalid && bresp != `TCC_RESP_OKAY)
    else $error("narrow write not refused");

  a_upper_reads_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    arvalid && arready && araddr == AW'(`TCC_CFG_OFF) |=> rvalid && rdata[31:16] == 16'h0)
    else $error("upper configuration bits not zero");

  // Checks on configuration gating
  a_dir_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    ch2_channel_enable |=> $stable(cfg_r[1:0]))
    else $error("direction changed while enabled");

  a_ctl_locked: assert property (@(posedge aclk) disable iff (!aresetn)
    output_lock_level == `TCC_LOCK_FULL && ch2_b[`TCC_F_MS] == 2'b00
    |=> $stable(cfg_r[6:4]))
    else $error("compare control changed under lock");

  // Checks on the prepare signal
  a_clear_on_trig: assert property (@(posedge aclk) disable iff (!aresetn)
    ch2_b[`TCC_F_MS] == 2'b00 && ch2_b[`TCC_F_CEN] && filtered_external_trigger
    |=> !ch2_prepare_signal)
    else $error("prepare not cleared by external trigger");

  a_timing_holds: assert property (@(posedge aclk) disable iff (!aresetn)
    ch2_b[`TCC_F_MS] == 2'b00 && ch2_b[`TCC_F_CTL] == 3'h0 &&
    !(ch2_b[`TCC_F_CEN] && filtered_external_trigger) |=> $stable(ch2_prepare_signal))
    else $error("prepare moved in timing mode");

  a_force_low: assert property (@(posedge aclk) disable iff (!aresetn)
    (ch3_b[`TCC_F_MS] == 2'b00 && ch3_b[`TCC_F_CTL] == 3'h4) [*2] |-> !ch3_prepare_signal)
    else $error("forced low not low");

  a_force_high: assert property (@(posedge aclk) disable iff (!aresetn)
    ch3_b[`TCC_F_MS] == 2'b00 && ch3_b[`TCC_F_CTL] == 3'h5 &&
    !(ch3_b[`TCC_F_CEN] && filtered_external_trigger) |=> ch3_prepare_signal)
    else $error("forced high not high");

  // Check on the capture prescaler
  a_psc_cleared: assert property (@(posedge aclk) disable iff (!aresetn)
    !ch2_channel_enable |=> !ch2_capture_event)
    else $error("capture while channel disabled");

endmodule

// file: rtl/tcc_map.svh
// Register offsets, field positions and reset values of the channel 2/3 mode block
`ifndef TCC_MAP_SVH
`define TCC_MAP_SVH

// Byte offsets on the register bus
`define TCC_CFG_OFF 8'h1c
`define TCC_CMP2_OFF 8'h34
`define TCC_CMP3_OFF 8'h38
`define TCC_STAT_OFF 8'h40

// Reset values
`define TCC_CFG_RST 16'h0000
`define TCC_CMP_RST 32'h0000_0000
`define TCC_STAT_PAD 28'h000_0000

// Byte lane of each channel inside the configuration word
`define TCC_CH2_LSB 0
`define TCC_CH3_LSB 8

// Fields inside one channel byte, output compare view
`define TCC_F_MS 1:0
`define TCC_F_FEN 2
`define TCC_F_SEN 3
`define TCC_F_CTL 6:4
`define TCC_F_CEN 7

// Fields inside one channel byte, input capture view
`define TCC_F_PSC 3:2
`define TCC_F_FLT 7:4

// Lock level that freezes the compare control fields
`define TCC_LOCK_FULL 2'b11

// Bus answers and strobes
`define TCC_RESP_OKAY 2'b00
`define TCC_RESP_SLVERR 2'b10
`define TCC_RESP_DECERR 2'b11
`define TCC_STRB_FULL 4'hf

`endif

// file: rtl/tcc_pkg.sv
// Types shared by the channel 2/3 mode block
package tcc_pkg;

  // Compare output control codes, in their encoded order
  typedef enum logic [2:0] {
    tcc_timing,
    tcc_set,
    tcc_clear,
    tcc_toggle,
    tcc_force_low,
    tcc_force_high,
    tcc_pwm0,
    tcc_pwm1
  } tcc_cmp_mode_e;

  // Direction and capture source select codes
  typedef enum logic [1:0] {
    tcc_dir_out,
    tcc_dir_own,
    tcc_dir_other,
    tcc_dir_trig
  } tcc_dir_e;

endpackage

// file: rtl/tcc_out_chan.sv
// Output compare logic of one channel: shadowed compare value and prepare signal
module tcc_out_chan #(
  parameter int CW = 16
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic out_mode,
  input wire logic [2:0] mode,
  input wire logic clear_en,
  input wire logic shadow_en,
  input wire logic fast_en,
  input wire logic [CW-1:0] cmp_wr,
  input wire logic [CW-1:0] cnt,
  input wire logic count_down,
  input wire logic update_ev,
  input wire logic trig_edge,
  input wire logic ext_trig,
  output logic prep
);

  tcc_pkg::tcc_cmp_mode_e mode_e;
  tcc_pkg::tcc_cmp_mode_e mode_r;
  logic [CW-1:0] cmp_act_r;
  logic lt, gt, eq;
  logic lt_r, gt_r, down_r;
  logic prep_nxt;

  // PWM level from the comparison; mode 1 is the inverse of mode 0
  function automatic logic pwm_lvl(input logic inv, input logic down, input logic l,
                                   input logic g);
    logic lvl;
    lvl = down ? !g : l;
    return lvl ^ inv;
  endfunction

  assign mode_e = tcc_pkg::tcc_cmp_mode_e'(mode);
  assign lt = cnt < cmp_act_r;
  assign gt = cnt > cmp_act_r;
  assign eq = cnt == cmp_act_r;

  // Active compare value, loaded at update events when shadowed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cmp_act_r <= '0;
    end else if (!shadow_en || update_ev) begin
      cmp_act_r <= cmp_wr;
    end
  end

  // History of mode and comparison for PWM change detection
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_r <= tcc_pkg::tcc_timing;
      lt_r <= 1'b0;
      gt_r <= 1'b0;
      down_r <= 1'b0;
    end else begin
      mode_r <= mode_e;
      lt_r <= lt;
      gt_r <= gt;
      down_r <= count_down;
    end
  end

  // Next prepare level, active high
  always_comb begin
    prep_nxt = prep;
    if (out_mode) begin
      case (mode_e)
        tcc_pkg::tcc_timing: prep_nxt = prep;
        tcc_pkg::tcc_set: if (eq) prep_nxt = 1'b1;
        tcc_pkg::tcc_clear: if (eq) prep_nxt = 1'b0;
        tcc_pkg::tcc_toggle: if (eq) prep_nxt = !prep;
        tcc_pkg::tcc_force_low: prep_nxt = 1'b0;
        tcc_pkg::tcc_force_high: prep_nxt = 1'b1;
        tcc_pkg::tcc_pwm0, tcc_pkg::tcc_pwm1: begin
          if (mode_r == tcc_pkg::tcc_timing || lt != lt_r || gt != gt_r ||
              count_down != down_r) begin
            prep_nxt = pwm_lvl(mode_e == tcc_pkg::tcc_pwm1, count_down, lt, gt);
          end
          if (fast_en && trig_edge) begin
            prep_nxt = pwm_lvl(mode_e == tcc_pkg::tcc_pwm1, count_down, 1'b0, 1'b0);
          end
        end
        default: prep_nxt = prep;
      endcase
      if (clear_en && ext_trig) begin
        prep_nxt = 1'b0;
      end
    end
  end

  // Prepare register
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      prep <= 1'b0;
    end else begin
      prep <= prep_nxt;
    end
  end

endmodule

// file: rtl/tcc_in_chan.sv
// Input path of one channel: synchroniser, digital filter, source select, prescaler
module tcc_in_chan (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic raw_in,
  input wire logic other_filt,
  input wire logic itrig,
  input wire logic dts_en,
  input wire logic chan_en,
  input wire logic [1:0] ms,
  input wire logic [3:0] flt,
  input wire logic [1:0] psc,
  output logic filt,
  output logic capture
);

  logic sync1_r, sync2_r;
  logic [4:0] dts_cnt_r;
  logic [3:0] run_r;
  logic [2:0] div_k;
  logic [3:0] need_n;
  logic [4:0] mask;
  logic sample;
  logic src, src_r;
  logic [2:0] psc_cnt_r;

  // Filter code to {divider exponent, sample count}; exponent 0 is the timer clock
  function automatic logic [6:0] flt_cfg(input logic [3:0] code);
    case (code)
      4'h1: return {3'h0, 4'h2};
      4'h2: return {3'h0, 4'h4};
      4'h3: return {3'h0, 4'h8};
      4'h4: return {3'h1, 4'h6};
      4'h5: return {3'h1, 4'h8};
      4'h6: return {3'h2, 4'h6};
      4'h7: return {3'h2, 4'h8};
      4'h8: return {3'h3, 4'h6};
      4'h9: return {3'h3, 4'h8};
      4'ha: return {3'h4, 4'h5};
      4'hb: return {3'h4, 4'h6};
      4'hc: return {3'h4, 4'h8};
      4'hd: return {3'h5, 4'h5};
      4'he: return {3'h5, 4'h6};
      4'hf: return {3'h5, 4'h8};
      default: return {3'h0, 4'h1};
    endcase
  endfunction

  assign {div_k, need_n} = flt_cfg(flt);
  assign mask = (5'h01 << div_k) - 5'h01;
  assign sample = (div_k == 3'h0) || (dts_en && ((dts_cnt_r & mask) == 5'h00));

  // Two-stage synchroniser on the pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      sync1_r <= 1'b0;
      sync2_r <= 1'b0;
    end else begin
      sync1_r <= raw_in;
      sync2_r <= sync1_r;
    end
  end

  // Dead-time tick counter for the slower sampling rates
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      dts_cnt_r <= 5'h00;
    end else if (dts_en) begin
      dts_cnt_r <= dts_cnt_r + 5'h01;
    end
  end

  // Filter: a new level is taken after enough equal samples in a row
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      filt <= 1'b0;
      run_r <= 4'h0;
    end else if (flt == 4'h0) begin
      filt <= sync2_r;
      run_r <= 4'h0;
    end else if (sample) begin
      if (sync2_r == filt) begin
        run_r <= 4'h0;
      end else if (run_r + 4'h1 >= need_n) begin
        filt <= sync2_r;
        run_r <= 4'h0;
      end else begin
        run_r <= run_r + 4'h1;
      end
    end
  end

  // Capture source select
  always_comb begin
    case (tcc_pkg::tcc_dir_e'(ms))
      tcc_pkg::tcc_dir_own: src = filt;
      tcc_pkg::tcc_dir_other: src = other_filt;
      tcc_pkg::tcc_dir_trig: src = itrig;
      default: src = 1'b0;
    endcase
  end

  // Edge prescaler, cleared while the channel is disabled
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      src_r <= 1'b0;
      psc_cnt_r <= 3'h0;
      capture <= 1'b0;
    end else begin
      src_r <= src;
      capture <= 1'b0;
      if (!chan_en) begin
        psc_cnt_r <= 3'h0;
      end else if (ms != 2'b00 && src && !src_r) begin
        if (psc_cnt_r == (3'h1 << psc) - 3'h1) begin
          psc_cnt_r <= 3'h0;
          capture <= 1'b1;
        end else begin
          psc_cnt_r <= psc_cnt_r + 3'h1;
        end
      end
    end
  end

endmodule

// file: bench/tcc_cnt_model.sv
// Counter core model driving the timer side of the channel block
module tcc_cnt_model #(
  parameter int PERIOD = 64
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic count_down,
  output logic [15:0] counter_value,
  output logic update_event,
  output logic trigger_edge,
  output logic internal_trigger
);
  timeunit 1ns;
  timeprecision 100ps;

  // Wrapping counter, update pulse in the last cycle of each period
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      counter_value <= 16'h0000;
      update_event <= 1'b0;
    end else if (count_down) begin
      counter_value <= (counter_value == 16'h0000) ? 16'(PERIOD - 1) : counter_value - 16'h0001;
      update_event <= (counter_value == 16'h0001);
    end else begin
      counter_value <= (counter_value == 16'(PERIOD - 1)) ? 16'h0000 : counter_value + 16'h0001;
      update_event <= (counter_value == 16'(PERIOD - 2));
    end
  end

  // Trigger edge at count 16, apart from the update; a trigger source is always selected
  assign trigger_edge = (counter_value == 16'h0010);
  assign internal_trigger = counter_value[5];
endmodule

// file: bench/tb_top.sv
// Self-checking bench for the channel 2/3 mode block
`include "tcc_map.svh"

module tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, dn, ext, en2, en3, r2;
  logic awready, wready, bvalid, arready, rvalid, upd, trg, itr, p2, p3, c2, c3;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp, lock, r;
  logic [15:0] cv;
  int n_fail = 0;
  int tests_run = 0;
  int nc2 = 0;
  int nc3 = 0;

  tcc_top uut (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awvalid(awvalid),
    .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready),
    .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
    .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
    .counter_value(cv), .count_down(dn), .update_event(upd), .trigger_edge(trg),
    .internal_trigger(itr), .filtered_external_trigger(ext), .ch2_channel_enable(en2),
    .ch3_channel_enable(en3), .output_lock_level(lock), .ch2_raw_input(r2),
    .ch3_raw_input(1'b0), .ch2_prepare_signal(p2), .ch3_prepare_signal(p3),
    .ch2_capture_event(c2), .ch3_capture_event(c3));

  tcc_cnt_model pm (.aclk(aclk), .aresetn(aresetn), .count_down(dn), .counter_value(cv),
    .update_event(upd), .trigger_edge(trg), .internal_trigger(itr));

  // Clock, 25 ns period
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end

  // Capture pulse counters
  always @(posedge aclk) begin
    if (c2 === 1'b1) nc2 <= nc2 + 1;
    if (c3 === 1'b1) nc3 <= nc3 + 1;
  end

  task automatic give_verdict;
    if (n_fail == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    tests_run++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask

  // Bus write: address and data offered together, held until each is taken
  task automatic wr(input logic [7:0] a, input logic [31:0] v,
                    input logic [3:0] s = `TCC_STRB_FULL,
                    input logic [1:0] e = `TCC_RESP_OKAY);
    @(posedge aclk);
    awaddr <= a;
    awvalid <= 1'b1;
    wdata <= v;
    wstrb <= s;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    chk("bresp", {30'h0, e}, {30'h0, bresp});
  endtask

  // Bus read: waits for the read answer, takes data at that edge
  task automatic rd(input logic [7:0] a, output logic [31:0] v, output logic [1:0] rs);
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    v = rdata;
    rs = rresp;
    rready <= 1'b0;
  endtask

  task automatic wp(input logic e);
    for (int n = 0; n < 100 && p2 !== e; n++) @(posedge aclk);
    chk("ch2_prepare", {31'h0, e}, {31'h0, p2});
  endtask

  task automatic at(input int v);
    for (int n = 0; n < 200 && cv !== 16'(v); n++) @(posedge aclk);
    chk("counter_reached", v, {16'h0, cv});
    repeat (2) @(posedge aclk);
  endtask

  // Hang guard
  initial begin
    #(25 * 30000);
    n_fail++;
    give_verdict;
  end

  // Main sequence
  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready, dn, ext, en2, en3, r2} = 11'h000;
    {awaddr, araddr, wdata, wstrb, lock} = 54'h0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rd(`TCC_CFG_OFF, d, r);
    chk("cfg_reset", 32'h0000_0000, d);
    rd(8'h00, d, r);
    chk("unmapped", {30'h0, `TCC_RESP_DECERR}, {30'h0, r});
    wr(8'h00, 32'h0000_0000, `TCC_STRB_FULL, `TCC_RESP_DECERR);
    wr(`TCC_CMP2_OFF, 32'h0000_0014);
    wr(`TCC_CFG_OFF, 32'h0000_5010);
    wp(1'b1);
    chk("ch3_force_high", 32'h1, {31'h0, p3});
    wr(`TCC_CFG_OFF, 32'h0000_5000);
    repeat (80) @(posedge aclk);
    chk("ch2_timing_hold", 32'h1, {31'h0, p2});
    wr(`TCC_CFG_OFF, 32'h0000_5020);
    wp(1'b0);
    wr(`TCC_CFG_OFF, 32'h0000_5030);
    wp(1'b1);
    wr(`TCC_CFG_OFF, 32'h0000_40d0);
    ext <= 1'b1;
    wp(1'b0);
    chk("ch3_force_low", 32'h0, {31'h0, p3});
    ext <= 1'b0;
    wp(1'b1);
    // Both PWM modes in both counting directions, entered from timing
    for (int i = 0; i < 4; i++) begin
      dn <= i[1];
      wr(`TCC_CFG_OFF, 32'h0000_0000);
      wr(`TCC_CFG_OFF, i[0] ? 32'h0000_0070 : 32'h0000_0060);
      at(10);
      chk("pwm_low_count", {31'h0, ~i[0]}, {31'h0, p2});
      at(40);
      chk("pwm_high_count", {31'h0, i[0]}, {31'h0, p2});
    end
    dn <= 1'b0;
    wr(`TCC_CFG_OFF, 32'h0000_0000);
    wr(`TCC_CFG_OFF, 32'h0000_0068);
    at(1);
    wr(`TCC_CMP2_OFF, 32'h0000_0032);
    at(40);
    chk("shadow_old", 32'h0, {31'h0, p2});
    at(40);
    chk("shadow_new", 32'h1, {31'h0, p2});
    // Fast response: the trigger at count 16 acts as a match and the level holds
    wr(`TCC_CFG_OFF, 32'h0000_006c);
    at(30);
    chk("fast_trigger", 32'h0, {31'h0, p2});
    wr(`TCC_CFG_OFF, 32'h0000_0000, 4'h3, `TCC_RESP_SLVERR);
    lock <= `TCC_LOCK_FULL;
    wr(`TCC_CFG_OFF, 32'h0000_0010);
    rd(`TCC_CFG_OFF, d, r);
    chk("cfg_locked", 32'h0000_0068, d);
    lock <= 2'b00;
    en2 <= 1'b1;
    wr(`TCC_CFG_OFF, 32'h0000_0001);
    rd(`TCC_CFG_OFF, d, r);
    chk("dir_refused", 32'h0000_0000, d);
    en2 <= 1'b0;
    wr(`TCC_CFG_OFF, 32'h0000_0225);
    en2 <= 1'b1;
    en3 <= 1'b1;
    // Four rising edges on the channel 2 pin, each followed by a glitch the filter drops
    repeat (4) begin
      repeat (8) @(posedge aclk);
      r2 <= 1'b1;
      repeat (8) @(posedge aclk);
      r2 <= 1'b0;
      repeat (8) @(posedge aclk);
      r2 <= 1'b1;
      repeat (2) @(posedge aclk);
      r2 <= 1'b0;
    end
    repeat (10) @(posedge aclk);
    chk("ch2_captures", 32'd2, nc2);
    chk("ch3_captures", 32'd4, nc3);
    // Channel 3 switched to the internal trigger while disabled, then one rise
    at(40);
    en3 <= 1'b0;
    wr(`TCC_CFG_OFF, 32'h0000_0325);
    en3 <= 1'b1;
    at(40);
    chk("ch3_trig_capture", 32'd5, nc3);
    give_verdict;
  end
endmodule
